// [verilog/mfs_supervisor.sv]
/*
 * Mechanism fault supervisor: timeouts and retries over tray, slider,
 * disc read, power calibration, focus, recording and memory-area writes;
 * latches a fault class and mode digit; temperature stop; memory init.
 * Assumes sensor pins arrive asynchronously and the temperature word is
 * already stable in the clock domain when it is sampled.
 */
// Contract
// - Tray open not done in 4.5 s: abandon and command close.
// - Fallback close not done in 4.5 s: command open again.
// - Second open not done in 4.5 s: halt, tray fault.
// - Tray close not done in 4.5 s: switch to opening.
// - Open after failed close not done in 4.5 s: halt, tray fault.
// - Slider reverse: home switch must go high in 3.4 s else slider fault.
// - Then forward: switch must go low in 300 ms else slider fault.
// - Then reverse again: switch high in 300 ms else slider fault.
// - No Q nor ATIP per 1 s window: three retries, then read fault.
// - Calibration read search fails after two retries: power fault.
// - Calibration write speed fail or search retries spent: power fault.
// - Focus fails after disc discrimination: halt, focus fault.
// - Unrecovered track jump while recording: halt, recording fault.
// - ATIP unreadable 4 s continuously while recording: recording fault.
// - Memory-area write not done in 60 s: halt, disc fault.
// - TOC or memory-area read fails or incomplete: disc fault.
// - RF present at disc end boundary at record start: disc fault.
// - Temperature at or above +70 or at or below -15: warn, stop all.
// - Scroll plus menu with no disc: initialize parameter memory.
// - Disc loaded during init: copy text to memory when tray opens.
// - Service code is fault letter plus hex mode digit at failure.
// - Stop key held 10 s in stop state: show service code.
`timescale 1ns/1ps
`default_nettype none

module mfs_supervisor
    import mfs_pkg::*;
#(
    parameter logic [39:0] TRAY_TMO = TRAY_TMO_CYC,
    parameter logic [39:0] SLD_REV_TMO = SLD_REV_CYC,
    parameter logic [39:0] SLD_SHORT_TMO = SLD_SHORT_CYC,
    parameter logic [39:0] READ_WIN = READ_WIN_CYC,
    parameter logic [39:0] ATIP_LOSS = ATIP_LOSS_CYC,
    parameter logic [39:0] PMA_TMO = PMA_TMO_CYC,
    parameter logic [39:0] SVC_HOLD = SVC_HOLD_CYC
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Mechanism side.
    input wire mfs_sense_t sense,
    output mfs_drive_t drive,
    // Firmware requests and temperature.
    input wire mfs_req_t req,
    input wire logic signed [7:0] temp_c,
    // Front panel.
    input wire mfs_keys_t keys,
    output mfs_panel_t panel
);

    typedef struct packed {
        mfs_state_t st;
        logic [39:0] tmr;
        logic [39:0] aux;
        logic [4:0] tries;
        logic [3:0] mode;
        logic [7:0] fclass;
        logic [3:0] fmode;
        logic init_pend;
        mfs_drive_t drv;
        mfs_panel_t pnl;
    } mfs_state_reg_t;

    logic [1:0] rst_sync_ff;
    logic rst_ok;
    mfs_sense_t s1_ff;
    mfs_sense_t s2_ff;
    mfs_keys_t k1_ff;
    mfs_keys_t k2_ff;
    mfs_keys_t k3_ff;
    mfs_state_reg_t st_ff;
    mfs_state_reg_t nxt_st;
    logic tmo;
    logic too_hot;

    ////////////////////////////////////////////////////////////////////////
    // Reset release and input synchronisers.

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_ok = rst_sync_ff[1];

    always_ff @(posedge clock or negedge rst_ok) begin
        if (!rst_ok) begin
            s1_ff <= '0;
            s2_ff <= '0;
            k1_ff <= '0;
            k2_ff <= '0;
            k3_ff <= '0;
        end else begin
            s1_ff <= sense;
            s2_ff <= s1_ff;
            k1_ff <= keys;
            k2_ff <= k1_ff;
            k3_ff <= k2_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Step sequencer.

    // A helper that leaves the timer free-running would hide a missed
    // restart, so every entry into a monitored step clears it.
    function automatic mfs_state_reg_t go(mfs_state_reg_t s, mfs_state_t t);
        mfs_state_reg_t r;
        r = s;
        r.st = t;
        r.tmr = 40'h0;
        return r;
    endfunction

    function automatic mfs_state_reg_t fail(mfs_state_reg_t s,
                                            logic [7:0] c);
        mfs_state_reg_t r;
        r = go(s, ST_HALT);
        r.fclass = c;
        r.fmode = s.mode;
        r.drv = '0;
        r.drv.halt = 1'b1;
        return r;
    endfunction

    assign too_hot = (temp_c >= TEMP_HI) || (temp_c <= TEMP_LO);

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tmr = st_ff.tmr + 40'h1;
        tmo = 1'b0;
        nxt_st.pnl.nvm_init = 1'b0;
        nxt_st.pnl.nvm_copy_text = 1'b0;
        if (req.mode != 4'h0 || st_ff.st == ST_IDLE) begin
            nxt_st.mode = req.mode;
        end
        unique case (st_ff.st)
            ST_IDLE: begin
                nxt_st.drv = '0;
                if (req.tray_open) begin
                    nxt_st = go(nxt_st, ST_OPEN1);
                    nxt_st.drv.tray_open = 1'b1;
                end else if (req.tray_close) begin
                    nxt_st = go(nxt_st, ST_CLOSE1);
                    nxt_st.drv.tray_close = 1'b1;
                end else if (req.slider_home) begin
                    nxt_st = go(nxt_st, ST_SLD_REV);
                    nxt_st.drv.slider_rev = 1'b1;
                end else if (req.disc_read) begin
                    nxt_st = go(nxt_st, ST_READ);
                    nxt_st.tries = 5'h0;
                end else if (req.pca_read) begin
                    nxt_st = go(nxt_st, ST_PCA_RD);
                    nxt_st.tries = 5'h0;
                end else if (req.pca_write) begin
                    nxt_st = go(nxt_st, ST_PCA_WR);
                    nxt_st.tries = 5'h0;
                end else if (req.rec_start) begin
                    if (s2_ff.rf_at_end) begin
                        nxt_st = fail(nxt_st, FC_DISC);
                    end else begin
                        nxt_st = go(nxt_st, ST_REC);
                        nxt_st.aux = 40'h0;
                    end
                end else if (req.pma_write) begin
                    nxt_st = go(nxt_st, ST_PMA);
                end
            end
            ST_OPEN1: begin
                tmo = st_ff.tmr >= TRAY_TMO - 40'h1;
                if (s2_ff.tray_open_done) begin
                    nxt_st = go(nxt_st, ST_IDLE);
                end else if (tmo) begin
                    nxt_st = go(nxt_st, ST_CLOSE_FB);
                    nxt_st.drv.tray_open = 1'b0;
                    nxt_st.drv.tray_close = 1'b1;
                end
            end
            ST_CLOSE_FB: begin
                tmo = st_ff.tmr >= TRAY_TMO - 40'h1;
                if (s2_ff.tray_close_done || tmo) begin
                    nxt_st = go(nxt_st, ST_OPEN2);
                    nxt_st.drv.tray_close = 1'b0;
                    nxt_st.drv.tray_open = 1'b1;
                end
            end
            ST_OPEN2, ST_OPEN_FB: begin
                tmo = st_ff.tmr >= TRAY_TMO - 40'h1;
                if (s2_ff.tray_open_done) begin
                    nxt_st = go(nxt_st, ST_IDLE);
                end else if (tmo) begin
                    nxt_st = fail(nxt_st, FC_TRAY);
                end
            end
            ST_CLOSE1: begin
                tmo = st_ff.tmr >= TRAY_TMO - 40'h1;
                if (s2_ff.tray_close_done) begin
                    nxt_st = go(nxt_st, ST_IDLE);
                end else if (tmo) begin
                    nxt_st = go(nxt_st, ST_OPEN_FB);
                    nxt_st.drv.tray_close = 1'b0;
                    nxt_st.drv.tray_open = 1'b1;
                end
            end
            ST_SLD_REV: begin
                tmo = st_ff.tmr >= SLD_REV_TMO - 40'h1;
                if (s2_ff.inner_home_switch) begin
                    nxt_st = go(nxt_st, ST_SLD_FWD);
                    nxt_st.drv.slider_rev = 1'b0;
                    nxt_st.drv.slider_fwd = 1'b1;
                end else if (tmo) begin
                    nxt_st = fail(nxt_st, FC_SLIDER);
                end
            end
            ST_SLD_FWD: begin
                tmo = st_ff.tmr >= SLD_SHORT_TMO - 40'h1;
                if (!s2_ff.inner_home_switch) begin
                    nxt_st = go(nxt_st, ST_SLD_REV2);
                    nxt_st.drv.slider_fwd = 1'b0;
                    nxt_st.drv.slider_rev = 1'b1;
                end else if (tmo) begin
                    nxt_st = fail(nxt_st, FC_SLIDER);
                end
            end
            ST_SLD_REV2: begin
                tmo = st_ff.tmr >= SLD_SHORT_TMO - 40'h1;
                if (s2_ff.inner_home_switch) begin
                    nxt_st = go(nxt_st, ST_IDLE);
                    nxt_st.drv.slider_rev = 1'b0;
                end else if (tmo) begin
                    nxt_st = fail(nxt_st, FC_SLIDER);
                end
            end
            ST_READ: begin
                tmo = st_ff.tmr >= READ_WIN - 40'h1;
                if (s2_ff.toc_fail) begin
                    nxt_st = fail(nxt_st, FC_DISC);
                end else if (s2_ff.subq_ok || s2_ff.atip_ok) begin
                    nxt_st = go(nxt_st, ST_IDLE);
                end else if (tmo && st_ff.tries == READ_RETRIES) begin
                    nxt_st = fail(nxt_st, FC_READ);
                end else if (tmo) begin
                    nxt_st = go(nxt_st, ST_READ);
                    nxt_st.tries = st_ff.tries + 5'h1;
                end
            end
            ST_PCA_RD: begin
                if (s2_ff.search_ok) begin
                    nxt_st = go(nxt_st, ST_IDLE);
                end else if (s2_ff.search_fail) begin
                    if (st_ff.tries == PCA_READ_RETRIES) begin
                        nxt_st = fail(nxt_st, FC_POWER);
                    end else begin
                        nxt_st.tries = st_ff.tries + 5'h1;
                    end
                end
            end
            ST_PCA_WR: begin
                if (s2_ff.speed_fail) begin
                    nxt_st = fail(nxt_st, FC_POWER);
                end else if (s2_ff.search_ok) begin
                    nxt_st = go(nxt_st, ST_IDLE);
                end else if (s2_ff.search_fail) begin
                    if (st_ff.tries == PCA_WRITE_RETRIES) begin
                        nxt_st = fail(nxt_st, FC_POWER);
                    end else begin
                        nxt_st.tries = st_ff.tries + 5'h1;
                    end
                end
            end
            ST_REC: begin
                nxt_st.aux = s2_ff.atip_ok ? 40'h0 : st_ff.aux + 40'h1;
                if (s2_ff.jump_lost) begin
                    nxt_st = fail(nxt_st, FC_REC);
                end else if (st_ff.aux >= ATIP_LOSS - 40'h1) begin
                    nxt_st = fail(nxt_st, FC_REC);
                end else if (req.rec_stop) begin
                    nxt_st = go(nxt_st, ST_IDLE);
                end
            end
            ST_PMA: begin
                tmo = st_ff.tmr >= PMA_TMO - 40'h1;
                if (s2_ff.pma_done) begin
                    nxt_st = go(nxt_st, ST_IDLE);
                end else if (tmo) begin
                    nxt_st = fail(nxt_st, FC_DISC);
                end
            end
            ST_HALT: begin
                nxt_st.tmr = st_ff.tmr;
            end
        endcase
        // Focus loss after discrimination ends any step.
        if (s2_ff.discrim_done && s2_ff.focus_fail &&
            st_ff.st != ST_HALT) begin
            nxt_st = fail(nxt_st, FC_FOCUS);
        end
        // Temperature stop overrides every step and drive command, not the panel init and code logic below, and is sticky until reset.
        if (too_hot || st_ff.pnl.temp_warn) begin
            nxt_st = go(nxt_st, ST_HALT);
            nxt_st.drv = '0;
            nxt_st.drv.halt = 1'b1;
            nxt_st.pnl.temp_warn = 1'b1;
        end
        // Two-key memory init; text copy waits for a tray open.
        // The edge is taken behind the synchroniser so a metastable first
        // stage never reaches the decision.
        if (k2_ff.scroll && k2_ff.menu && !(k3_ff.scroll && k3_ff.menu) &&
            st_ff.st == ST_IDLE) begin
            if (!s2_ff.disc_loaded) begin
                nxt_st.pnl.nvm_init = 1'b1;
            end else begin
                nxt_st.init_pend = 1'b1;
            end
        end
        if (st_ff.init_pend && s2_ff.tray_open_done) begin
            nxt_st.init_pend = 1'b0;
            nxt_st.pnl.nvm_copy_text = 1'b1;
        end
        // Stop key hold in the stop state shows the latched code.
        if (k2_ff.stop && st_ff.mode == MD_STOP && st_ff.st == ST_IDLE) begin
            if (st_ff.aux >= SVC_HOLD - 40'h1) begin
                nxt_st.pnl.svc_show = 1'b1;
            end else begin
                nxt_st.aux = st_ff.aux + 40'h1;
            end
        end else if (st_ff.st == ST_IDLE && nxt_st.st == ST_IDLE) begin
            nxt_st.aux = 40'h0;
            nxt_st.pnl.svc_show = k2_ff.stop && st_ff.pnl.svc_show;
        end
        nxt_st.pnl.svc_char0 = nxt_st.fclass;
        nxt_st.pnl.svc_char1 = (nxt_st.fmode < 4'ha) ?
            8'h30 + {4'h0, nxt_st.fmode} : 8'h37 + {4'h0, nxt_st.fmode};
    end

    always_ff @(posedge clock or negedge rst_ok) begin
        if (!rst_ok) begin
            st_ff <= '{st: ST_IDLE, mode: 4'h2, fclass: FC_NONE,
                       pnl: '{svc_char0: FC_NONE, svc_char1: 8'h32,
                              default: '0},
                       default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign drive = st_ff.drv;
    assign panel = st_ff.pnl;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    chk_tray_fallback: assert property (@(posedge clock) disable iff (!rst_ok)
        st_ff.st == ST_OPEN1 && !s2_ff.tray_open_done &&
        st_ff.tmr == TRAY_TMO - 40'h1 && !too_hot && !st_ff.pnl.temp_warn
        && !(s2_ff.discrim_done && s2_ff.focus_fail)
        |=> st_ff.st == ST_CLOSE_FB && drive.tray_close)
        else $error("tray open timeout did not fall back to close");
    chk_tray_reopen: assert property (@(posedge clock) disable iff (!rst_ok)
        $rose(st_ff.st == ST_OPEN2) |-> drive.tray_open && !drive.tray_close)
        else $error("fallback close did not reopen");
    chk_tray_fault: assert property (@(posedge clock) disable iff (!rst_ok)
        $changed(st_ff.fclass) && st_ff.fclass == FC_TRAY
        |-> $past(st_ff.st) inside {ST_OPEN2, ST_OPEN_FB})
        else $error("tray fault from wrong step");
    chk_close_fallback: assert property (@(posedge clock)
        disable iff (!rst_ok)
        $rose(st_ff.st == ST_OPEN_FB) |-> $past(st_ff.st) == ST_CLOSE1)
        else $error("open fallback entered from wrong step");
    chk_slider_fault: assert property (@(posedge clock) disable iff (!rst_ok)
        $changed(st_ff.fclass) && st_ff.fclass == FC_SLIDER
        |-> drive.halt && $past(st_ff.st) inside
            {ST_SLD_REV, ST_SLD_FWD, ST_SLD_REV2})
        else $error("slider fault from wrong step");
    chk_read_retries: assert property (@(posedge clock) disable iff (!rst_ok)
        st_ff.st == ST_READ |-> st_ff.tries <= READ_RETRIES)
        else $error("read retries exceeded");
    chk_temp_stop: assert property (@(posedge clock) disable iff (!rst_ok)
        too_hot |=> st_ff.st == ST_HALT && panel.temp_warn && drive.halt
            && !drive.tray_open && !drive.slider_rev)
        else $error("temperature did not stop actions");
    chk_code_mode: assert property (@(posedge clock) disable iff (!rst_ok)
        $changed(st_ff.fclass) |-> st_ff.fmode == $past(st_ff.mode))
        else $error("service code mode digit mismatch");
    chk_timer_restart: assert property (@(posedge clock)
        disable iff (!rst_ok)
        $changed(st_ff.st) |-> st_ff.tmr == 40'h0)
        else $error("step timer not restarted");

endmodule

`default_nettype wire

// [inc/mfs_pkg.sv]
/*
 * Package for the mechanism fault supervisor: timing counts, fault class
 * letters, mechanism mode digits, state encoding and carrier structs.
 * Assumes a 100 MHz system clock.
 */
package mfs_pkg;

    localparam int unsigned CLK_HZ = 100_000_000;

    // Times in their own units, and cycle counts derived from them.
    localparam int unsigned TRAY_TMO_MS = 4500;
    localparam int unsigned SLD_REV_TMO_MS = 3400;
    localparam int unsigned SLD_SHORT_TMO_MS = 300;
    localparam int unsigned READ_WIN_MS = 1000;
    localparam int unsigned ATIP_LOSS_MS = 4000;
    localparam int unsigned PMA_TMO_MS = 60000;
    localparam int unsigned SVC_HOLD_MS = 10000;
    localparam int unsigned MS_CYC = CLK_HZ / 1000;

    localparam logic [39:0] TRAY_TMO_CYC = 40'(TRAY_TMO_MS) * 40'(MS_CYC);
    localparam logic [39:0] SLD_REV_CYC = 40'(SLD_REV_TMO_MS) * 40'(MS_CYC);
    localparam logic [39:0] SLD_SHORT_CYC =
        40'(SLD_SHORT_TMO_MS) * 40'(MS_CYC);
    localparam logic [39:0] READ_WIN_CYC = 40'(READ_WIN_MS) * 40'(MS_CYC);
    localparam logic [39:0] ATIP_LOSS_CYC = 40'(ATIP_LOSS_MS) * 40'(MS_CYC);
    localparam logic [39:0] PMA_TMO_CYC = 40'(PMA_TMO_MS) * 40'(MS_CYC);
    localparam logic [39:0] SVC_HOLD_CYC = 40'(SVC_HOLD_MS) * 40'(MS_CYC);

    // Retry budgets.
    localparam logic [4:0] READ_RETRIES = 5'h03;
    localparam logic [4:0] PCA_READ_RETRIES = 5'h02;
    localparam logic [4:0] PCA_WRITE_RETRIES = 5'h13;

    // Temperature thresholds in signed degrees Celsius.
    localparam logic signed [7:0] TEMP_HI = 8'sh46;
    localparam logic signed [7:0] TEMP_LO = -8'sh0f;

    // Fault class letters as ASCII display characters.
    localparam logic [7:0] FC_NONE = 8'h20;
    localparam logic [7:0] FC_TRAY = 8'h4c;
    localparam logic [7:0] FC_SLIDER = 8'h45;
    localparam logic [7:0] FC_READ = 8'h50;
    localparam logic [7:0] FC_POWER = 8'h43;
    localparam logic [7:0] FC_FOCUS = 8'h46;
    localparam logic [7:0] FC_REC = 8'h41;
    localparam logic [7:0] FC_DISC = 8'h64;

    typedef enum logic [3:0] {
        MD_PLAY = 4'h0,
        MD_OPEN = 4'h1,
        MD_STOP = 4'h2,
        MD_SETUP = 4'h5,
        MD_TOC_READ = 4'h6,
        MD_SEARCH = 4'h8,
        MD_REC_PAUSE = 4'h9,
        MD_REC = 4'ha,
        MD_TOC_REC = 4'hb,
        MD_OPC = 4'hc,
        MD_TOC_CHECK = 4'hd,
        MD_PMA = 4'he
    } mfs_mode_t;

    // Gray codes along the tray open path and between the three slider steps.
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_OPEN1 = 4'h1,
        ST_CLOSE_FB = 4'h3,
        ST_OPEN2 = 4'h2,
        ST_CLOSE1 = 4'h6,
        ST_OPEN_FB = 4'h7,
        ST_SLD_REV = 4'h5,
        ST_SLD_FWD = 4'h4,
        ST_SLD_REV2 = 4'hc,
        ST_READ = 4'hd,
        ST_PCA_RD = 4'hf,
        ST_PCA_WR = 4'he,
        ST_REC = 4'ha,
        ST_PMA = 4'hb,
        ST_HALT = 4'h9
    } mfs_state_t;

    // Sensor and step-result inputs from the mechanism side.
    typedef struct packed {
        logic tray_open_done;
        logic tray_close_done;
        logic inner_home_switch;
        logic subq_ok;
        logic atip_ok;
        logic search_ok;
        logic search_fail;
        logic speed_fail;
        logic discrim_done;
        logic focus_fail;
        logic jump_lost;
        logic pma_done;
        logic toc_fail;
        logic rf_at_end;
        logic disc_loaded;
    } mfs_sense_t;

    // Requests from the controlling firmware, one-cycle pulses, plus the mode digit level.
    typedef struct packed {
        logic tray_open;
        logic tray_close;
        logic slider_home;
        logic disc_read;
        logic pca_read;
        logic pca_write;
        logic rec_start;
        logic rec_stop;
        logic pma_write;
        logic [3:0] mode;
    } mfs_req_t;

    // Front-panel key levels.
    typedef struct packed {
        logic stop;
        logic scroll;
        logic menu;
    } mfs_keys_t;

    // Drive commands to the mechanism.
    typedef struct packed {
        logic tray_open;
        logic tray_close;
        logic slider_rev;
        logic slider_fwd;
        logic halt;
    } mfs_drive_t;

    // Display and memory outputs.
    typedef struct packed {
        logic temp_warn;
        logic svc_show;
        logic [7:0] svc_char0;
        logic [7:0] svc_char1;
        logic nvm_init;
        logic nvm_copy_text;
    } mfs_panel_t;

endpackage

// [bench/mfs_mech.sv]
/* Mechanism model: tray end stops and slider home switch.
   Assumes supervisor drive levels on the same clock. */
`timescale 1ns/1ps
`default_nettype none
module mfs_mech
    import mfs_pkg::*;
(
    // Clock and commands.
    input wire logic clock,
    input wire mfs_drive_t drive,
    input wire logic stuck,
    input wire logic [7:0] dly,
    // Sensors.
    output logic od,
    output logic cd,
    output logic hm
);
    logic [7:0] n = 8'h00;
    logic o = 1'b0, c = 1'b1, h = 1'b0;
    mfs_drive_t p = '0;
    // A jammed mechanism leaves every sensor low, not at its last level.
    assign od = o & ~stuck;
    assign cd = c & ~stuck;
    assign hm = h & ~stuck;
    always @(posedge clock) begin
        p <= drive;
        n <= (drive != p) ? 8'h00 : n + 8'h01;
        if (n == dly) begin
            if (drive.tray_open) {o, c} <= 2'b10;
            if (drive.tray_close) {o, c} <= 2'b01;
            if (drive.slider_rev) h <= 1'b1;
            if (drive.slider_fwd) h <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [bench/mfs_supervisor_test.sv]
/* Self-checking bench for the mechanism fault supervisor.
   Assumes the mechanism model and shortened timeout parameters. */
`timescale 1ns/1ps
`default_nettype none
module mfs_supervisor_test
    import mfs_pkg::*;
;
    typedef struct packed {
        logic [8:0] rq;
        logic [14:0] sn;
        logic jam;
        logic [7:0] fc;
    } mfs_tc_t;
    localparam int TT = 40;
    localparam int SH = 40;
    // Per case: request flags, sensed levels, jammed mechanism, class.
    localparam mfs_tc_t TC [14] = '{
        '{9'h100, 15'h0000, 1'b1, FC_TRAY},
        '{9'h080, 15'h0000, 1'b1, FC_TRAY},
        '{9'h040, 15'h0000, 1'b1, FC_SLIDER},
        '{9'h020, 15'h0000, 1'b0, FC_READ},
        '{9'h010, 15'h0100, 1'b0, FC_POWER},
        '{9'h008, 15'h0080, 1'b0, FC_POWER},
        '{9'h004, 15'h0010, 1'b0, FC_REC},
        '{9'h000, 15'h0060, 1'b0, FC_FOCUS},
        '{9'h001, 15'h0000, 1'b0, FC_DISC},
        '{9'h004, 15'h0002, 1'b0, FC_DISC},
        '{9'h020, 15'h0004, 1'b0, FC_DISC},
        '{9'h004, 15'h0000, 1'b0, FC_REC},
        '{9'h100, 15'h0000, 1'b0, FC_NONE},
        '{9'h040, 15'h0000, 1'b0, FC_NONE}
    };
    localparam logic signed [7:0] TL [4] = '{8'sh46, 8'sh45, -8'sh0f, -8'sh0e};
    logic clock = 1'b0, rst_n = 1'b0, stuck = 1'b0, od, cd, hm;
    logic [14:0] sb = 15'h0000;
    logic [7:0] dly = 8'h0a;
    logic [3:0] md = 4'h2;
    mfs_sense_t sense;
    mfs_req_t req = '0;
    logic signed [7:0] temp_c = 8'sh14;
    mfs_keys_t keys = '0;
    mfs_drive_t drive;
    mfs_panel_t panel;
    int n_fail = 0, samples_checked = 0, n_init = 0, n_copy = 0;
    always #5 clock = ~clock;
    assign sense = {od, cd, hm, sb[11:0]};
    mfs_supervisor #(.TRAY_TMO(40'(TT)), .SLD_REV_TMO(40'h3c),
        .SLD_SHORT_TMO(40'h1e), .READ_WIN(40'h32), .ATIP_LOSS(40'h3c),
        .PMA_TMO(40'h50), .SVC_HOLD(40'(SH))) dut_u (.clock(clock),
        .rst_n(rst_n),
        .sense(sense), .drive(drive), .req(req), .temp_c(temp_c),
        .keys(keys), .panel(panel));
    mfs_mech mech_u (.clock(clock), .drive(drive), .stuck(stuck), .dly(dly),
        .od(od), .cd(cd), .hm(hm));
    always @(posedge clock) begin
        n_init += int'(panel.nvm_init === 1'b1);
        n_copy += int'(panel.nvm_copy_text === 1'b1);
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    function automatic logic [7:0] hexch(input logic [3:0] m);
        return 8'(m) + ((m < 4'ha) ? 8'h30 : 8'h37);
    endfunction
    // Halt is final, so every case starts from a fresh reset.
    task automatic do_reset();
        @(posedge clock);
        rst_n <= 1'b0;
        {sb, stuck, keys, temp_c} <= {15'h0, 1'b0, 3'h0, 8'sh14};
        req <= {9'h0, md};
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
    endtask
    task automatic issue(input logic [8:0] rq);
        @(posedge clock);
        req <= {rq, md};
        @(posedge clock);
        req <= {9'h0, md};
    endtask
    task automatic fault_case(input mfs_tc_t t);
        do_reset();
        {sb, stuck} <= {t.sn, t.jam};
        dly <= t.rq[8] ? 8'h19 : 8'h0a;
        // Sensed levels need two cycles through the synchroniser.
        repeat (2) @(posedge clock);
        issue(t.rq);
        if (t.rq[8] && t.jam) begin
            repeat (TT - 6) @(negedge clock);
            chk(drive.tray_open === 1'b1, "still opening");
            repeat (12) @(negedge clock);
            chk(drive.tray_close === 1'b1, "no fallback close");
            repeat (TT) @(negedge clock);
            chk(drive.tray_open === 1'b1, "no reopen");
        end
        for (int w = 0; w < 600 && drive.halt !== 1'b1; w++) @(negedge clock);
        chk(drive.halt === (t.fc != FC_NONE), "halt");
        chk(panel.svc_char0 === t.fc, "fault class");
        if (t.fc != FC_NONE) chk(panel.svc_char1 === hexch(md), "mode");
    endtask
    task automatic temp_case(input logic signed [7:0] t);
        logic w;
        w = (t >= 8'sh46) || (t <= -8'sh0f);
        do_reset();
        temp_c <= t;
        issue(9'h100);
        repeat (5) @(negedge clock);
        chk(panel.temp_warn === w, "temp warn");
        chk(!w || drive.tray_open === 1'b0, "not stopped");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(30));
        foreach (TC[k]) begin
            md = 4'($urandom_range(0, 14));
            while (md inside {4'h3, 4'h4, 4'h7}) md = 4'($urandom_range(0, 14));
            fault_case(TC[k]);
        end
        for (int i = 0; i < 6; i++) temp_case(i < 4 ? TL[i] : 8'($urandom));
        md = 4'h2;
        do_reset();
        keys <= 3'b100;
        repeat (SH - 8) @(negedge clock);
        chk(panel.svc_show === 1'b0, "early show");
        repeat (16) @(negedge clock);
        chk(panel.svc_show === 1'b1, "no show");
        do_reset();
        keys <= 3'b011;
        repeat (8) @(negedge clock);
        chk(n_init == 1, "no init");
        do_reset();
        sb <= 15'h0001;
        keys <= 3'b011;
        repeat (8) @(posedge clock);
        issue(9'h100);
        repeat (60) @(negedge clock);
        chk(n_copy == 1 && n_init == 1, "text copy");
        tally_and_finish();
    end
    initial begin
        repeat (30000) @(posedge clock);
        n_fail++;
        $display("[ERR] %0t timeout", $time);
        tally_and_finish();
    end
endmodule
`default_nettype wire
